// *** hdl/rpt_map.svh ***
/*
 * Register offsets, field positions, reset values and timing figures
 * of the periodic timer block. Assumes byte addresses on a 32-bit bus.
 */
`ifndef RPT_MAP_SVH
`define RPT_MAP_SVH

// Register byte offsets
`define RPT_ADDR_CTRL 8'h00
`define RPT_ADDR_CRYSTAL_PPM_TRIM 8'h04
`define RPT_ADDR_SLOW_CLOCK_SOURCE_SELECT 8'h08
`define RPT_ADDR_COUNT 8'h0c
`define RPT_ADDR_PER 8'h10
`define RPT_ADDR_CMP 8'h14
`define RPT_ADDR_PITCTRL 8'h18
`define RPT_ADDR_FLAGS 8'h1c

// Field positions
`define RPT_CTRL_CNT_EN 0
`define RPT_CTRL_CORR_EN 2
`define RPT_CTRL_PRESC_LO 3
`define RPT_CTRL_PRESC_HI 6
`define RPT_PIT_EN 0
`define RPT_PIT_PERIOD_LO 3
`define RPT_PIT_PERIOD_HI 6
`define RPT_CRYSTAL_PPM_TRIM_SIGN 7
`define RPT_CRYSTAL_PPM_TRIM_ERR_HI 6
`define RPT_FLAG_OVF 0
`define RPT_FLAG_CMP 1
`define RPT_FLAG_PIT 2

// Reset values and figures
`define RPT_PER_RESET 16'hffff
`define RPT_CORR_INTERVAL 1000000
`define RPT_PIT_PERIOD_MAX 4'he
`define RPT_TAP_LO 5
`define RPT_TAP_HI 12

`endif

// *** hdl/rpt_pkg.sv ***
/*
 * Types shared by the periodic timer block.
 * Assumes rpt_map.svh supplies the numeric constants.
 */
package rpt_pkg;
    typedef logic [15:0] rpt_count_t;
    typedef logic [14:0] rpt_presc_t;
    typedef logic [3:0] rpt_sel_t;
    typedef logic [7:0] rpt_crystal_ppm_trim_t;
endpackage

// *** hdl/rpt_tick_gen.sv ***
/*
 * Slow clock source selection and tick generation.
 * Assumes every slow source is a level synchronous to hclk and much slower.
 */
`timescale 1ns/1ps
module rpt_tick_gen
    import rpt_pkg::*;
#(
    parameter int NSRC = 4
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic [NSRC-1:0] src,
    input wire logic [1:0] sel,
    output logic tick
);
    logic lvl_reg;
    logic armed_reg;
    logic tick_reg;

    // One selected level feeds the whole block; no false tick after reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lvl_reg <= 1'b0;
            armed_reg <= 1'b0;
            tick_reg <= 1'b0;
        end else if (ce) begin
            lvl_reg <= src[sel];
            armed_reg <= 1'b1;
            tick_reg <= armed_reg & src[sel] & ~lvl_reg;
        end
    end

    assign tick = tick_reg & ce;
endmodule

// *** hdl/rpt_top.sv ***
/*
 * Real-time counter and periodic interrupt timer behind an AHB-Lite slave.
 * Assumes slow clock sources arrive as levels synchronous to hclk and that
 * ce stays high while the bus master runs transfers.
 */
// The implementer's own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "rpt_map.svh"

// Summary of operation
// - One selected slow clock drives both functions
// - Counter runs while its enable is one
// - Periodic timer enable independent of counter enable
// - Shared prescaler feeds counter and periodic timer
// - Prescaler stops only when both enables clear
// - Enabling never resets the prescaler phase
// - Timer output toggles each half period
// - Sixteen-cycle period taps prescaler bit three
// - Correction enable applies signed ppm trim
// - Trim cycles spread over million-cycle interval
// - Correction reaches count and timer intervals, except the count for positive trim at prescaler setting 0
// - Disabling correction finishes current interval first
// - Overflow and compare events last one slow period
// - Level taps divide slow clock 64 to 8192
// - Events fire on count after equality
// - Overflow returns the count to zero
// - Timer periods range 4 to 32768 cycles
module rpt_top
    import rpt_pkg::*;
#(
    parameter int CORR_INTERVAL = `RPT_CORR_INTERVAL,
    parameter int NSRC = 4
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [NSRC-1:0] slow_src,
    output logic periodic_interrupt_timer,
    output logic overflow_event,
    output logic compare_match,
    output logic [7:0] level_tap_event
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Bus-side shadows
    logic counter_enable_reg;
    logic freq_correction_enable_reg;
    rpt_sel_t presc_sel_reg;
    rpt_crystal_ppm_trim_t crystal_ppm_trim_reg;
    logic [1:0] slow_clock_source_select_reg;
    rpt_count_t per_reg;
    rpt_count_t cmp_reg;
    logic periodic_timer_enable_reg;
    rpt_sel_t period_reg;
    logic [2:0] flags_reg;

    // Settings as seen by the slow logic
    logic cnt_en_a_reg;
    logic pit_en_a_reg;
    logic corr_en_a_reg;
    rpt_sel_t presc_a_reg;
    rpt_sel_t period_a_reg;
    rpt_crystal_ppm_trim_t crystal_ppm_trim_a_reg;

    // Slow-side state
    rpt_presc_t presc_reg;
    rpt_count_t count_reg;
    logic corr_act_reg;
    logic [19:0] icnt_reg;
    logic [20:0] acc_reg;
    logic ovf_ev_reg;
    logic cmp_ev_reg;
    logic pit_out_reg;

    // Bus state
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [31:0] rdata_next;

    logic tick;
    logic run;
    logic [15:0] presc_sum;
    logic [15:0] presc_next;
    rpt_presc_t mask;
    logic cnt_tick;
    logic corr_do;
    logic [20:0] acc_sum;
    logic icnt_wrap;
    logic tap;
    logic pit_next;
    logic pit_rise;
    logic ovf_hit;
    logic cmp_hit;
    logic addr_ok;
    logic wr_ctrl;
    logic wr_flags;

    rpt_tick_gen #(
        .NSRC(NSRC)
    ) u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .src(slow_src),
        .sel(slow_clock_source_select_reg),
        .tick(tick)
    );

    // AHB-Lite address phase
    assign addr_ok = hsel & htrans[1] & hready & ce;
    assign wr_ctrl = wr_pend_reg & ce;
    assign wr_flags = wr_ctrl && wr_addr_reg == `RPT_ADDR_FLAGS;

    always_comb begin
        rdata_next = 32'h0;
        case (haddr[7:0])
            `RPT_ADDR_CTRL: begin
                rdata_next[`RPT_CTRL_CNT_EN] = counter_enable_reg;
                rdata_next[`RPT_CTRL_CORR_EN] = freq_correction_enable_reg;
                rdata_next[`RPT_CTRL_PRESC_HI:`RPT_CTRL_PRESC_LO] = presc_sel_reg;
            end
            `RPT_ADDR_CRYSTAL_PPM_TRIM: rdata_next[7:0] = crystal_ppm_trim_reg;
            `RPT_ADDR_SLOW_CLOCK_SOURCE_SELECT: rdata_next[1:0] = slow_clock_source_select_reg;
            `RPT_ADDR_COUNT: rdata_next[15:0] = count_reg;
            `RPT_ADDR_PER: rdata_next[15:0] = per_reg;
            `RPT_ADDR_CMP: rdata_next[15:0] = cmp_reg;
            `RPT_ADDR_PITCTRL: begin
                rdata_next[`RPT_PIT_EN] = periodic_timer_enable_reg;
                rdata_next[`RPT_PIT_PERIOD_HI:`RPT_PIT_PERIOD_LO] = period_reg;
            end
            `RPT_ADDR_FLAGS: rdata_next[2:0] = flags_reg;
            default: rdata_next = 32'h0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h0;
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (ce) begin
            wr_pend_reg <= addr_ok & hwrite;
            if (addr_ok) begin
                wr_addr_reg <= haddr[7:0];
            end
            if (addr_ok && !hwrite) begin
                hrdata <= rdata_next;
            end
        end
    end

    // Software-written settings
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            counter_enable_reg <= 1'b0;
            freq_correction_enable_reg <= 1'b0;
            presc_sel_reg <= 4'h0;
            crystal_ppm_trim_reg <= 8'h0;
            slow_clock_source_select_reg <= 2'h0;
            per_reg <= `RPT_PER_RESET;
            cmp_reg <= 16'h0;
            periodic_timer_enable_reg <= 1'b0;
            period_reg <= 4'h0;
        end else if (wr_ctrl) begin
            case (wr_addr_reg)
                `RPT_ADDR_CTRL: begin
                    counter_enable_reg <= hwdata[`RPT_CTRL_CNT_EN];
                    freq_correction_enable_reg <= hwdata[`RPT_CTRL_CORR_EN];
                    presc_sel_reg <= hwdata[`RPT_CTRL_PRESC_HI:`RPT_CTRL_PRESC_LO];
                end
                `RPT_ADDR_CRYSTAL_PPM_TRIM: crystal_ppm_trim_reg <= hwdata[7:0];
                `RPT_ADDR_SLOW_CLOCK_SOURCE_SELECT: slow_clock_source_select_reg <= hwdata[1:0];
                `RPT_ADDR_PER: per_reg <= hwdata[15:0];
                `RPT_ADDR_CMP: cmp_reg <= hwdata[15:0];
                `RPT_ADDR_PITCTRL: begin
                    periodic_timer_enable_reg <= hwdata[`RPT_PIT_EN];
                    period_reg <= hwdata[`RPT_PIT_PERIOD_HI:`RPT_PIT_PERIOD_LO];
                end
                default: ;
            endcase
        end
    end

    // Settings cross to the slow logic only on a slow tick
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_en_a_reg <= 1'b0;
            pit_en_a_reg <= 1'b0;
            corr_en_a_reg <= 1'b0;
            presc_a_reg <= 4'h0;
            period_a_reg <= 4'h0;
            crystal_ppm_trim_a_reg <= 8'h0;
        end else if (tick) begin
            cnt_en_a_reg <= counter_enable_reg;
            pit_en_a_reg <= periodic_timer_enable_reg;
            corr_en_a_reg <= freq_correction_enable_reg;
            presc_a_reg <= presc_sel_reg;
            period_a_reg <= period_reg;
            crystal_ppm_trim_a_reg <= crystal_ppm_trim_reg;
        end
    end

    // Shared prescaler with trim
    assign run = cnt_en_a_reg | pit_en_a_reg;
    assign acc_sum = acc_reg + {14'h0, crystal_ppm_trim_a_reg[`RPT_CRYSTAL_PPM_TRIM_ERR_HI:0]};
    assign corr_do = corr_act_reg && acc_sum >= 21'(CORR_INTERVAL);
    assign icnt_wrap = icnt_reg == 20'(CORR_INTERVAL - 1);

    always_comb begin
        presc_sum = {1'b0, presc_reg} + 16'h1;
        if (corr_do && crystal_ppm_trim_a_reg[`RPT_CRYSTAL_PPM_TRIM_SIGN]) begin
            presc_sum = {1'b0, presc_reg};
        end else if (corr_do) begin
            presc_sum = {1'b0, presc_reg} + 16'h2;
        end
        presc_next = presc_sum;
    end

    assign mask = 15'(15'h1 << presc_a_reg) - 15'h1;
    assign cnt_tick = tick & cnt_en_a_reg
        & ((presc_next & ~{1'b0, mask}) != ({1'b0, presc_reg} & ~{1'b0, mask}));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            presc_reg <= 15'h0;
        end else if (tick && run) begin
            presc_reg <= presc_next[14:0];
        end
    end

    // Correction interval; a disable waits for the interval end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            icnt_reg <= 20'h0;
            acc_reg <= 21'h0;
            corr_act_reg <= 1'b0;
        end else if (tick && run) begin
            if (icnt_wrap || !corr_act_reg) begin
                icnt_reg <= 20'h0;
                acc_reg <= 21'h0;
                corr_act_reg <= corr_en_a_reg;
            end else begin
                icnt_reg <= icnt_reg + 20'h1;
                acc_reg <= corr_do ? acc_sum - 21'(CORR_INTERVAL) : acc_sum;
            end
        end
    end

    // Counter, wrap and compare
    assign ovf_hit = cnt_tick && count_reg == per_reg;
    assign cmp_hit = cnt_tick && count_reg == cmp_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_reg <= 16'h0;
        end else if (cnt_tick) begin
            count_reg <= ovf_hit ? 16'h0 : count_reg + 16'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ovf_ev_reg <= 1'b0;
            cmp_ev_reg <= 1'b0;
        end else if (tick) begin
            ovf_ev_reg <= ovf_hit;
            cmp_ev_reg <= cmp_hit;
        end
    end

    // Periodic timer square output
    assign tap = period_a_reg != 4'h0 && period_a_reg <= `RPT_PIT_PERIOD_MAX
        && presc_reg[period_a_reg];
    assign pit_next = pit_en_a_reg & tap;
    assign pit_rise = pit_next & ~pit_out_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pit_out_reg <= 1'b0;
        end else if (ce) begin
            pit_out_reg <= pit_next;
        end
    end

    // Sticky flags; a new event beats a clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_reg <= 3'h0;
        end else if (ce) begin
            if (wr_flags) begin
                flags_reg <= flags_reg & ~hwdata[2:0];
            end
            if (tick && ovf_hit) begin
                flags_reg[`RPT_FLAG_OVF] <= 1'b1;
            end
            if (tick && cmp_hit) begin
                flags_reg[`RPT_FLAG_CMP] <= 1'b1;
            end
            if (pit_rise) begin
                flags_reg[`RPT_FLAG_PIT] <= 1'b1;
            end
        end
    end

    assign periodic_interrupt_timer = pit_out_reg;
    assign overflow_event = ovf_ev_reg;
    assign compare_match = cmp_ev_reg;
    assign level_tap_event = presc_reg[`RPT_TAP_HI:`RPT_TAP_LO];

    // Checks
    a_presc_stopped: assert property (
        !run |=> $stable(presc_reg)
    ) else $error("prescaler moved while both functions were off");
    a_settings_hold: assert property (
        !tick |=> $stable(cnt_en_a_reg) && $stable(presc_a_reg)
    ) else $error("slow setting changed between ticks");
    a_wrap_zero: assert property (
        ovf_hit |=> count_reg == 16'h0 && overflow_event
    ) else $error("overflow did not clear the count");
    a_cmp_event: assert property (
        cmp_hit |=> compare_match && flags_reg[`RPT_FLAG_CMP]
    ) else $error("compare match missed");
    a_event_len: assert property (
        tick && !ovf_hit |=> !overflow_event
    ) else $error("overflow event outlived one slow period");
    a_pit_bit3: assert property (
        ce && pit_en_a_reg && period_a_reg == 4'h3
            |=> periodic_interrupt_timer == $past(presc_reg[3])
    ) else $error("sixteen-cycle output not on bit three");
    a_corr_skip: assert property (
        tick && run && corr_do && !crystal_ppm_trim_a_reg[`RPT_CRYSTAL_PPM_TRIM_SIGN]
            |=> presc_reg == 15'($past(presc_reg) + 15'h2)
    ) else $error("positive trim did not skip a count");
    a_corr_hold: assert property (
        tick && run && corr_do && crystal_ppm_trim_a_reg[`RPT_CRYSTAL_PPM_TRIM_SIGN]
            |=> $stable(presc_reg)
    ) else $error("negative trim did not insert a count");
    a_corr_finish: assert property (
        corr_act_reg && !icnt_wrap && icnt_reg != 20'h0 |=> corr_act_reg
    ) else $error("correction stopped inside its interval");
    a_counter_off: assert property (
        !cnt_en_a_reg |=> $stable(count_reg)
    ) else $error("counter advanced while disabled");
    a_pit_flag: assert property (
        pit_rise && ce |=> flags_reg[`RPT_FLAG_PIT] && periodic_interrupt_timer
    ) else $error("timer rise did not set its flag");
endmodule

// *** verification/rpt_top_bench.sv ***
/*
 * Self-checking bench for rpt_top: AHB-Lite register tasks and
 * interval measurements on the timer outputs and event lines.
 * Assumes the slow sources are hclk-synchronous levels made here.
 */
`timescale 1ns/1ps
`include "rpt_map.svh"
module rpt_top_bench
    import rpt_pkg::*;
();
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic ce = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [7:0] div_cnt = 8'h00;
    logic [3:0] slow_src;
    logic pit_out;
    logic ovf_ev;
    logic cmp_ev;
    logic [7:0] taps;
    int miscompares = 0;
    int n_checks = 0;
    logic [31:0] rd;
    rpt_count_t unused_count;
    localparam logic [7:0] WA [8] = '{`RPT_ADDR_CTRL, `RPT_ADDR_PITCTRL, `RPT_ADDR_CRYSTAL_PPM_TRIM,
        `RPT_ADDR_SLOW_CLOCK_SOURCE_SELECT, `RPT_ADDR_PER, `RPT_ADDR_CMP, `RPT_ADDR_COUNT, 8'h20};
    localparam logic [31:0] WD [8] = '{32'hffffff7a, 32'hffffff7a, 32'hffffffb5,
        32'hfffffffe, 32'hffff0004, 32'hffff0002, 32'hffffffff, 32'hffffffff};
    localparam logic [31:0] WE [8] = '{32'h78, 32'h78, 32'hb5, 32'h2, 32'h4, 32'h2, 32'h0,
        32'h0};

    // Bus clock and slow sources of 8, 16, 64 and 128 hclk periods
    always #20 hclk = ~hclk;
    always @(posedge hclk) div_cnt <= div_cnt + 8'h01;
    assign slow_src = {div_cnt[6], div_cnt[5], div_cnt[3], div_cnt[2]};

    rpt_top #(.CORR_INTERVAL(64), .NSRC(4)) rpt_top_inst (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .hsel(1'b1),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .slow_src(slow_src),
        .periodic_interrupt_timer(pit_out),
        .overflow_event(ovf_ev),
        .compare_match(cmp_ev),
        .level_tap_event(taps)
    );

    task automatic report_and_stop();
        if (miscompares == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_cycles(input int got, input int exp);
        n_checks++;
        if (got != exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Waits for hready high at a rising edge, bounded
    task automatic bus_wait();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            miscompares++;
            report_and_stop();
        end
    endtask

    task automatic ahb_xfer(input logic [7:0] addr, input logic wr, input logic [31:0] wdata,
        output logic [31:0] rdata);
        haddr <= {24'h0, addr};
        htrans <= 2'h2;
        hwrite <= wr;
        bus_wait();
        htrans <= 2'h0;
        hwdata <= wdata;
        bus_wait();
        rdata = hrdata;
        check_word({31'h0, hresp}, 32'h0);
    endtask

    task automatic reg_write(input logic [7:0] addr, input logic [31:0] data);
        ahb_xfer(addr, 1'b1, data, rd);
    endtask

    task automatic reg_check(input logic [7:0] addr, input logic [31:0] exp);
        ahb_xfer(addr, 1'b0, 32'h0, rd);
        check_word(rd, exp);
    endtask

    function automatic logic pick(input int w);
        case (w)
            0: return pit_out;
            1: return ovf_ev;
            2: return cmp_ev;
            default: return taps[w-3];
        endcase
    endfunction

    // Counts edges until the chosen output shows the level, bounded
    task automatic wait_level(input int w, input logic lvl, output int n);
        n = 0;
        while (pick(w) !== lvl && n < 5000) begin
            @(posedge hclk);
            n++;
        end
        if (pick(w) !== lvl) begin
            miscompares++;
            report_and_stop();
        end
    endtask

    // High time and full period, from one rise to the next
    task automatic measure(input int w, input int total, input int high);
        int n;
        int hi;
        int lo;
        wait_level(w, 1'b0, n);
        wait_level(w, 1'b1, n);
        wait_level(w, 1'b0, hi);
        wait_level(w, 1'b1, lo);
        check_cycles(hi, high);
        check_cycles(hi + lo, total);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge hclk);
    endtask

    initial begin
        int n;
        unused_count = '0;
        settle(2);
        hresetn <= 1'b1;
        settle(1);
        // Reset values, unmapped word reads zero
        for (int i = 0; i < 9; i++) begin
            reg_check(8'(i * 4), (i == 4) ? 32'h0000ffff : 32'h0);
        end
        // Read-back, unused bits, read-only count, unmapped write
        for (int i = 0; i < 8; i++) begin
            reg_write(WA[i], WD[i]);
            reg_check(WA[i], WE[i]);
        end
        reg_write(`RPT_ADDR_CTRL, 32'h0);
        reg_write(`RPT_ADDR_PITCTRL, 32'h0);
        reg_write(`RPT_ADDR_CRYSTAL_PPM_TRIM, 32'h0);
        reg_write(`RPT_ADDR_SLOW_CLOCK_SOURCE_SELECT, 32'h0);
        settle(300);
        check_word({24'h0, taps}, 32'h0);
        check_word({31'h0, pit_out}, 32'h0);
        // Counter with compare 2 and period 4 at three prescaler settings
        for (int p = 0; p < 3; p++) begin
            reg_write(`RPT_ADDR_CTRL, 32'((p << 3) | 1));
            settle(200);
            measure(1, 40 << p, 8);
            reg_check(`RPT_ADDR_COUNT, 32'h0);
            measure(2, 40 << p, 8);
            wait_level(2, 1'b0, n);
            wait_level(2, 1'b1, n);
            wait_level(1, 1'b1, n);
            check_cycles(n, 16 << p);
        end
        reg_check(`RPT_ADDR_FLAGS, 32'h3);
        reg_write(`RPT_ADDR_CTRL, 32'h0);
        settle(100);
        ahb_xfer(`RPT_ADDR_COUNT, 1'b0, 32'h0, rd);
        settle(400);
        reg_check(`RPT_ADDR_COUNT, rd);
        reg_write(`RPT_ADDR_FLAGS, 32'h3);
        reg_check(`RPT_ADDR_FLAGS, 32'h0);
        // Periodic timer at 4-tick and 16-tick periods, counter off
        for (int p = 1; p < 4; p += 2) begin
            reg_write(`RPT_ADDR_PITCTRL, 32'((p << 3) | 1));
            settle(300);
            measure(0, 8 << (p + 1), 4 << (p + 1));
        end
        for (int i = 0; i < 2; i++) begin
            measure(3 + i, 512 << i, 256 << i);
        end
        // Clock enable low freezes all state
        ce <= 1'b0;
        settle(1);
        rd = {23'h0, pit_out, taps};
        settle(64);
        check_word({23'h0, pit_out, taps}, rd);
        ce <= 1'b1;
        ahb_xfer(`RPT_ADDR_COUNT, 1'b0, 32'h0, rd);
        settle(300);
        reg_check(`RPT_ADDR_COUNT, rd);
        reg_check(`RPT_ADDR_FLAGS, 32'h4);
        // Second source drives both functions
        reg_write(`RPT_ADDR_SLOW_CLOCK_SOURCE_SELECT, 32'h1);
        reg_write(`RPT_ADDR_CTRL, 32'h1);
        settle(300);
        measure(0, 256, 128);
        measure(1, 80, 16);
        reg_write(`RPT_ADDR_CTRL, 32'h0);
        reg_write(`RPT_ADDR_SLOW_CLOCK_SOURCE_SELECT, 32'h0);
        // Slow by half, then double speed, then correction off
        reg_write(`RPT_ADDR_CRYSTAL_PPM_TRIM, 32'ha0);
        reg_write(`RPT_ADDR_CTRL, 32'h0c);
        settle(1200);
        measure(0, 256, 128);
        reg_write(`RPT_ADDR_CRYSTAL_PPM_TRIM, 32'h40);
        reg_write(`RPT_ADDR_CTRL, 32'h04);
        settle(1200);
        measure(0, 64, 32);
        reg_write(`RPT_ADDR_CTRL, 32'h0);
        settle(1200);
        measure(0, 128, 64);
        // Period code 15 keeps the output low
        reg_write(`RPT_ADDR_PITCTRL, 32'h79);
        settle(40);
        check_word({31'h0, pit_out}, 32'h0);
        // Reset in mid-run
        hresetn <= 1'b0;
        settle(2);
        check_word({31'h0, pit_out}, 32'h0);
        check_word({24'h0, taps}, 32'h0);
        hresetn <= 1'b1;
        settle(1);
        reg_check(`RPT_ADDR_PITCTRL, 32'h0);
        reg_check(`RPT_ADDR_PER, 32'h0000ffff);
        report_and_stop();
    end
endmodule
